// file: atc_top.sv
// Auto-torque adaptive coil-current loop with its register file
`timescale 1ns/1ps
`include "atc_params.svh"
module atc_top (
  input wire logic clk_in, // 25 MHz clock
  input wire logic reset_in, // Synchronous reset, active high
  input wire atc_pkg::atc_reg_req_s reg_req_in, // Register write request
  input wire logic half_cycle_in, // One-cycle pulse per electrical half-cycle
  input wire atc_pkg::atc_count_t load_sample_in, // Raw load count of the ending half-cycle
  output logic [7:0] reg_rdata_out, // Read data for reg_req_in.addr, one cycle later
  output logic [7:0] coil_current_out, // Commanded coil current
  output logic learning_out // Learning routine running
);
  import atc_pkg::*;

  logic [7:0] upper_q;
  logic [7:0] upper_d;
  logic [7:0] lower_q;
  logic [7:0] lower_d;
  logic [7:0] pg_q;
  logic [7:0] pg_d;
  logic [7:0] dg_q;
  logic [7:0] dg_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] floor_q;
  logic [7:0] floor_d;
  logic [7:0] ceil_q;
  logic [7:0] ceil_d;
  logic [7:0] dthr_q;
  logic [7:0] dthr_d;
  logic [7:0] rsvd_q;
  logic [7:0] rsvd_d;
  logic [7:0] lrn_lo_q;
  logic [7:0] lrn_lo_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  atc_learn_e learn_q, learn_d;
  logic [5:0] learn_cnt_q, learn_cnt_d;
  atc_count_t hist_q [0:7];
  atc_count_t hist_d [0:7];
  atc_count_t count_q, count_d;
  logic signed [12:0] err_prev_q, err_prev_d;
  logic [2:0] wait_q, wait_d;
  logic [7:0] cur_q, cur_d;
  logic wr_ctrl;
  logic enable;
  logic [2:0] delay;
  logic [13:0] sum2;
  logic [13:0] sum4;
  logic [13:0] sum8;
  logic signed [12:0] err;
  logic signed [12:0] derr;
  logic signed [12:0] derr_abs;
  logic signed [21:0] p_term, d_term, corr;
  logic signed [9:0] step, target;
  logic done;

  assign wr_ctrl = reg_req_in.wr && (reg_req_in.addr == `ATC_ADDR_CTRL);
  assign enable = ctrl_q[`ATC_EN_BIT];
  assign delay = ctrl_q[`ATC_DLY_HI:`ATC_DLY_LO];
  assign done = (learn_q == LEARN_RUN) && half_cycle_in && (learn_cnt_q == `ATC_LEARN_HALF_CYCLES);

  // Register file and read path
  always_comb
  begin
    upper_d = upper_q;
    lower_d = lower_q;
    pg_d = pg_q;
    dg_d = dg_q;
    ctrl_d = ctrl_q;
    floor_d = floor_q;
    ceil_d = ceil_q;
    dthr_d = dthr_q;
    rsvd_d = rsvd_q;
    lrn_lo_d = lrn_lo_q;
    if (done)
    begin
      ctrl_d[`ATC_LRN_BIT] = 1'b0;
    end
    if (reg_req_in.wr)
    begin
      if (reg_req_in.addr == `ATC_ADDR_UPPER)
        upper_d = reg_req_in.wdata;
      else if (reg_req_in.addr == `ATC_ADDR_LOWER)
        lower_d = reg_req_in.wdata;
      else if (reg_req_in.addr == `ATC_ADDR_PGAIN)
        pg_d = reg_req_in.wdata;
      else if (reg_req_in.addr == `ATC_ADDR_DGAIN)
        dg_d = reg_req_in.wdata;
      else if (reg_req_in.addr == `ATC_ADDR_CTRL)
        ctrl_d = reg_req_in.wdata;
      else if (reg_req_in.addr == `ATC_ADDR_FLOOR)
        floor_d = reg_req_in.wdata;
      else if (reg_req_in.addr == `ATC_ADDR_CEIL)
        ceil_d = reg_req_in.wdata;
      else if (reg_req_in.addr == `ATC_ADDR_DTHR)
        dthr_d = reg_req_in.wdata;
      else if (reg_req_in.addr == `ATC_ADDR_RSVD14)
        rsvd_d = reg_req_in.wdata;
      else if (reg_req_in.addr == `ATC_ADDR_LRN_LO)
        lrn_lo_d = reg_req_in.wdata;
    end
    if (reg_req_in.addr == `ATC_ADDR_CNT_LO)
      rdata_d = count_q[7:0];
    else if (reg_req_in.addr == `ATC_ADDR_CNT_HI)
      rdata_d = {count_q[10:8], 5'h00};
    else if (reg_req_in.addr == `ATC_ADDR_LRN_LO)
      rdata_d = lrn_lo_q;
    else if (reg_req_in.addr == `ATC_ADDR_UPPER)
      rdata_d = upper_q;
    else if (reg_req_in.addr == `ATC_ADDR_LOWER)
      rdata_d = lower_q;
    else if (reg_req_in.addr == `ATC_ADDR_PGAIN)
      rdata_d = pg_q;
    else if (reg_req_in.addr == `ATC_ADDR_DGAIN)
      rdata_d = dg_q;
    else if (reg_req_in.addr == `ATC_ADDR_CTRL)
      rdata_d = ctrl_q;
    else if (reg_req_in.addr == `ATC_ADDR_FLOOR)
      rdata_d = floor_q;
    else if (reg_req_in.addr == `ATC_ADDR_CEIL)
      rdata_d = ceil_q;
    else if (reg_req_in.addr == `ATC_ADDR_DTHR)
      rdata_d = dthr_q;
    else if (reg_req_in.addr == `ATC_ADDR_RSVD14)
      rdata_d = rsvd_q;
    else if (reg_req_in.addr == `ATC_ADDR_READBACK)
      rdata_d = cur_q;
    else
      rdata_d = `ATC_RST_ZERO;
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      upper_q <= `ATC_RST_ZERO;
      lower_q <= `ATC_RST_ZERO;
      pg_q <= `ATC_RST_ZERO;
      dg_q <= `ATC_RST_ZERO;
      ctrl_q <= `ATC_RST_CTRL;
      floor_q <= `ATC_RST_FLOOR;
      ceil_q <= `ATC_RST_CEIL;
      dthr_q <= `ATC_RST_DTHR;
      rsvd_q <= `ATC_RST_RSVD14;
      lrn_lo_q <= `ATC_RST_ZERO;
      rdata_q <= `ATC_RST_ZERO;
    end
    else
    begin
      upper_q <= upper_d;
      lower_q <= lower_d;
      pg_q <= pg_d;
      dg_q <= dg_d;
      ctrl_q <= ctrl_d;
      floor_q <= floor_d;
      ceil_q <= ceil_d;
      dthr_q <= dthr_d;
      rsvd_q <= rsvd_d;
      lrn_lo_q <= lrn_lo_d;
      rdata_q <= rdata_d;
    end
  end

  // Learning routine: a fixed number of half-cycles with the current held at the ceiling
  always_comb
  begin
    learn_d = learn_q;
    learn_cnt_d = learn_cnt_q;
    case (learn_q)
      LEARN_IDLE:
      begin
        if (wr_ctrl && reg_req_in.wdata[`ATC_LRN_BIT])
        begin
          learn_d = LEARN_RUN;
          learn_cnt_d = 6'h00;
        end
      end
      LEARN_RUN:
      begin
        if (wr_ctrl && reg_req_in.wdata[`ATC_LRN_BIT])
          learn_cnt_d = 6'h00;
        else if (done)
          learn_d = LEARN_IDLE;
        else if (half_cycle_in)
          learn_cnt_d = learn_cnt_q + 6'h01;
      end
      default:
        learn_d = LEARN_IDLE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      learn_q <= LEARN_IDLE;
      learn_cnt_q <= 6'h00;
    end
    else
    begin
      learn_q <= learn_d;
      learn_cnt_q <= learn_cnt_d;
    end
  end

  // Averaging, PD correction and clamped current update
  always_comb
  begin
    hist_d[0] = load_sample_in;
    for (int i = 1; i < 8; i++)
      hist_d[i] = hist_q[i - 1];
    sum2 = 14'(hist_d[0]) + 14'(hist_d[1]);
    sum4 = sum2 + 14'(hist_d[2]) + 14'(hist_d[3]);
    sum8 = sum4 + 14'(hist_d[4]) + 14'(hist_d[5]) + 14'(hist_d[6]) + 14'(hist_d[7]);
    case (ctrl_q[`ATC_AVG_HI:`ATC_AVG_LO])
      `ATC_AVG_2: count_d = sum2[11:1];
      `ATC_AVG_4: count_d = sum4[12:2];
      `ATC_AVG_8: count_d = sum8[13:3];
      default: count_d = load_sample_in;
    endcase
    if (count_d > {3'h0, upper_q})
      err = 13'(count_d) - 13'(upper_q);
    else if (count_d < {3'h0, lower_q})
      err = 13'(count_d) - 13'(lower_q);
    else
      err = 13'sh0000;
    derr = err - err_prev_q;
    derr_abs = derr[12] ? -derr : derr;
    p_term = 22'(err) * $signed({1'b0, pg_q});
    d_term = 22'(derr) * $signed({1'b0, dg_q[`ATC_DGAIN_HI:0]});
    corr = (derr_abs > $signed({5'h00, dthr_q})) ? p_term + d_term : p_term;
    if ((corr >>> `ATC_CORR_SHIFT) > 22'(`ATC_STEP_LIMIT))
      step = `ATC_STEP_LIMIT;
    else if ((corr >>> `ATC_CORR_SHIFT) < -22'(`ATC_STEP_LIMIT))
      step = -`ATC_STEP_LIMIT;
    else
      step = 10'(corr >>> `ATC_CORR_SHIFT);
    target = $signed({2'h0, cur_q}) + step;
    err_prev_d = err_prev_q;
    wait_d = wait_q;
    cur_d = cur_q;
    if (!enable || learn_q == LEARN_RUN)
    begin
      cur_d = ceil_q;
      wait_d = 3'h0;
    end
    else if (half_cycle_in)
    begin
      err_prev_d = err;
      if (wait_q + 3'h1 >= delay)
      begin
        wait_d = 3'h0;
        if (target > $signed({2'h0, ceil_q}))
          cur_d = ceil_q;
        else if (target < $signed({2'h0, floor_q}))
          cur_d = floor_q;
        else
          cur_d = target[7:0];
      end
      else
      begin
        wait_d = wait_q + 3'h1;
        // A limit write may land while the wait runs
        if (cur_q > ceil_q)
          cur_d = ceil_q;
        else if (cur_q < floor_q)
          cur_d = floor_q;
      end
    end
    else if (cur_q > ceil_q)
      cur_d = ceil_q;
    else if (cur_q < floor_q)
      cur_d = floor_q;
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      for (int i = 0; i < 8; i++)
        hist_q[i] <= 11'h000;
      count_q <= 11'h000;
      err_prev_q <= 13'sh0000;
      wait_q <= 3'h0;
      cur_q <= `ATC_RST_CEIL;
    end
    else
    begin
      if (half_cycle_in)
      begin
        for (int i = 0; i < 8; i++)
          hist_q[i] <= hist_d[i];
        count_q <= count_d;
      end
      err_prev_q <= err_prev_d;
      wait_q <= wait_d;
      cur_q <= cur_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign coil_current_out = cur_q;
  assign learning_out = learn_q[1];
endmodule

// file: atc_params.svh
// Constants of the auto-torque current loop: addresses, fields, reset values
// How it works
// - Loop runs only while enable bit set
// - Writing one to bit 6 starts learning
// - Learning start bit self-clears when learning ends
// - Wait response-delay half-cycles before changing current
// - Load count is moving average over half-cycles
// - Codes 010,100,111 average 2,4,8 half-cycles
// - Other averaging codes use the raw count
// - Enabled current never below floor register
// - Enabled current never above ceiling register
// - Differential term only above differential threshold
// - Correction is P*e, plus D*de above threshold
// - Band upper edge from its register
// - Band lower edge from its register
// - Proportional gain from 8-bit register
// - Differential gain in bits 3-0; 7-4 reserved
// - Low learn constant held in register
// - 11-bit load count readable over two registers
// - Commanded current readable, between floor and ceiling
// - Disabled: commanded current reads ceiling value
`ifndef ATC_PARAMS_SVH
`define ATC_PARAMS_SVH
`define ATC_ADDR_CNT_LO 6'h1f
`define ATC_ADDR_CNT_HI 6'h20
`define ATC_ADDR_LRN_LO 6'h23
`define ATC_ADDR_UPPER 6'h24
`define ATC_ADDR_LOWER 6'h25
`define ATC_ADDR_PGAIN 6'h26
`define ATC_ADDR_DGAIN 6'h27
`define ATC_ADDR_CTRL 6'h28
`define ATC_ADDR_FLOOR 6'h29
`define ATC_ADDR_CEIL 6'h2a
`define ATC_ADDR_DTHR 6'h2b
`define ATC_ADDR_RSVD14 6'h2c
`define ATC_ADDR_READBACK 6'h2e
`define ATC_RST_ZERO 8'h00
`define ATC_RST_CTRL 8'h08
`define ATC_RST_FLOOR 8'h0a
`define ATC_RST_CEIL 8'hff
`define ATC_RST_DTHR 8'h05
`define ATC_RST_RSVD14 8'h0f
`define ATC_EN_BIT 7
`define ATC_LRN_BIT 6
`define ATC_DLY_HI 5
`define ATC_DLY_LO 3
`define ATC_AVG_HI 2
`define ATC_AVG_LO 0
`define ATC_DGAIN_HI 3
`define ATC_AVG_2 3'h2
`define ATC_AVG_4 3'h4
`define ATC_AVG_8 3'h7
`define ATC_LEARN_HALF_CYCLES 6'h20
`define ATC_CORR_SHIFT 4
`define ATC_STEP_LIMIT 10'sh0ff
`endif

// file: atc_pkg.sv
// Types shared by the auto-torque current loop
package atc_pkg;
  typedef struct packed {
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } atc_reg_req_s;
  typedef enum logic [1:0] {
    LEARN_IDLE = 2'b01,
    LEARN_RUN = 2'b10
  } atc_learn_e;
  typedef logic [10:0] atc_count_t;
endpackage

// file: atc_sva.sv
// Port checker for the auto-torque loop
`timescale 1ns/1ps
module atc_sva (
  input wire logic clk_in, // Clock
  input wire logic reset_in, // Reset
  input wire atc_pkg::atc_reg_req_s reg_req_in, // Request
  input wire logic half_cycle_in, // Pulse
  input wire atc_pkg::atc_count_t load_sample_in, // Sample
  input wire logic [7:0] reg_rdata_out, // Read data
  input wire logic [7:0] coil_current_out, // Current
  input wire logic learning_out // Learning
);
  import atc_pkg::*;
  logic en_q, en_d, wr_ctl;
  logic [7:0] flr_q, flr_d, cei_q, cei_d;
  logic [5:0] lc_q, lc_d;
  // Shadow of the fields the assertions need
  always_comb
  begin
    wr_ctl = reg_req_in.wr && reg_req_in.addr == 6'h28;
    en_d = wr_ctl ? reg_req_in.wdata[7] : en_q;
    flr_d = (reg_req_in.wr && reg_req_in.addr == 6'h29) ? reg_req_in.wdata : flr_q;
    cei_d = (reg_req_in.wr && reg_req_in.addr == 6'h2a) ? reg_req_in.wdata : cei_q;
    lc_d = (!learning_out || (wr_ctl && reg_req_in.wdata[6])) ? 6'h00 : lc_q + {5'h00, half_cycle_in};
  end
  always_ff @(posedge clk_in)
  begin
    en_q <= reset_in ? 1'b0 : en_d;
    flr_q <= reset_in ? 8'h0a : flr_d;
    cei_q <= reset_in ? 8'hff : cei_d;
    lc_q <= reset_in ? 6'h00 : lc_d;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_learn_req;
    wr_ctl && reg_req_in.wdata[6];
  endsequence
  sequence s_learn_on;
    learning_out [*2];
  endsequence
  chk_learn_start: assert property (s_learn_req |=> s_learn_on)
    else $error("learning did not start");
  chk_learn_len: assert property (!$past(reset_in) && $fell(learning_out) |-> lc_q == 6'h21)
    else $error("learning length wrong");
  chk_rdata_unmapped: assert property (!$past(reset_in) && !($past(reg_req_in.addr) inside {6'h1f, 6'h20,
    [6'h23:6'h2c], 6'h2e}) |-> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  chk_readback_value: assert property (!$past(reset_in) && $past(reg_req_in.addr) == 6'h2e
    |-> reg_rdata_out == $past(coil_current_out))
    else $error("readback differs from current");
  chk_count_pad: assert property ($past(reg_req_in.addr) == 6'h20 |-> reg_rdata_out[4:0] == 5'h00)
    else $error("count high byte padding set");
  chk_disabled_ceil: assert property (!$past(reset_in) && $past(!en_q) && $stable(cei_q)
    |-> coil_current_out == cei_q)
    else $error("disabled current not ceiling");
  chk_learn_ceil: assert property (!$past(reset_in) && $past(learning_out) && $stable(cei_q)
    |-> coil_current_out == cei_q)
    else $error("learning current not ceiling");
  chk_current_range: assert property (!$past(reset_in) && $past(en_q && !learning_out) && $stable(flr_q)
    && $stable(cei_q) && flr_q <= cei_q |-> coil_current_out >= flr_q && coil_current_out <= cei_q)
    else $error("current out of range");
endmodule
bind atc_top atc_sva chk (.clk_in(clk_in), .reset_in(reset_in), .reg_req_in(reg_req_in),
  .half_cycle_in(half_cycle_in), .load_sample_in(load_sample_in), .reg_rdata_out(reg_rdata_out),
  .coil_current_out(coil_current_out), .learning_out(learning_out));

// file: auto_torque_control_tb.sv
// Self-checking bench for the auto-torque loop
`timescale 1ns/1ps
module auto_torque_control_tb;
  import atc_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic half_cycle_in = 1'b0;
  atc_reg_req_s reg_req_in = '0;
  atc_count_t load_sample_in = '0;
  atc_count_t cnt = '0;
  logic [7:0] reg_rdata_out, coil_current_out;
  logic learning_out;
  int errors = 0;
  int checks_done = 0;
  logic [7:0] mdl [0:63];
  atc_count_t hist [$];
  atc_top uut (.clk_in(clk_in), .reset_in(reset_in), .reg_req_in(reg_req_in), .half_cycle_in(half_cycle_in),
    .load_sample_in(load_sample_in), .reg_rdata_out(reg_rdata_out), .coil_current_out(coil_current_out),
    .learning_out(learning_out));
  always #20 clk_in = ~clk_in;
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_req_in = '{1'b1, a, d};
    if (a inside {[6'h23:6'h2c]})
      mdl[a] = d;
    @(negedge clk_in);
    reg_req_in = '{1'b0, a, d};
    @(negedge clk_in);
  endtask
  function automatic logic [7:0] expv(input logic [5:0] a);
    case (a)
      6'h1f: return cnt[7:0];
      6'h20: return {cnt[10:8], 5'h00};
      6'h2e: return mdl[a];
      default: return (a inside {[6'h23:6'h2c]}) ? mdl[a] : 8'h00;
    endcase
  endfunction
  task automatic rdc(input logic [5:0] a);
    reg_req_in.addr = a;
    @(negedge clk_in);
    check({3'h0, reg_rdata_out}, {3'h0, expv(a)});
  endtask
  task automatic pulse(input atc_count_t s);
    half_cycle_in = 1'b1;
    load_sample_in = s;
    hist.push_front(s);
    @(negedge clk_in);
    half_cycle_in = 1'b0;
    @(negedge clk_in);
  endtask
  // Moving average of the newest samples, as the depth code selects
  function automatic atc_count_t avg(input logic [2:0] c);
    int k;
    int s;
    k = (c == 3'h2) ? 2 : (c == 3'h4) ? 4 : (c == 3'h7) ? 8 : 1;
    s = 0;
    for (int i = 0; i < k; i++)
      s += hist[i];
    return atc_count_t'(s / k);
  endfunction
  initial
  begin
    #(40 * 5000);
    errors++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(73));
    foreach (mdl[i])
      mdl[i] = 8'h00;
    mdl[6'h28] = 8'h08;
    mdl[6'h29] = 8'h0a;
    mdl[6'h2a] = 8'hff;
    mdl[6'h2b] = 8'h05;
    mdl[6'h2c] = 8'h0f;
    mdl[6'h2e] = 8'hff;
    repeat (3) @(negedge clk_in);
    reset_in = 1'b0;
    for (int a = 30; a < 48; a++)
      rdc(6'(a));
    for (int a = 30; a < 48; a++)
      wr(6'(a), (a == 40) ? 8'($urandom & 8'h3f) : 8'($urandom));
    mdl[6'h2e] = mdl[6'h2a];
    for (int a = 30; a < 48; a++)
      rdc(6'(a));
    for (int c = 0; c < 8; c++)
    begin
      wr(6'h28, 8'(8 + c));
      repeat (8) pulse(atc_count_t'($urandom));
      cnt = avg(3'(c));
      rdc(6'h1f);
      rdc(6'h20);
    end
    wr(6'h28, 8'h48);
    @(negedge clk_in);
    check({10'h0, learning_out}, 11'h1);
    rdc(6'h28);
    repeat (32) pulse('0);
    @(negedge clk_in);
    check({10'h0, learning_out}, 11'h1);
    pulse('0);
    @(negedge clk_in);
    check({10'h0, learning_out}, 11'h0);
    mdl[6'h28] = 8'h08;
    rdc(6'h28);
    wr(6'h29, 8'h10 + 8'($urandom % 64));
    wr(6'h2a, 8'hb0 + 8'($urandom % 64));
    wr(6'h24, 8'h80);
    wr(6'h25, 8'h40);
    wr(6'h26, 8'h40);
    wr(6'h27, 8'hf0);
    wr(6'h28, 8'h88);
    pulse('0);
    check({3'h0, coil_current_out}, {3'h0, mdl[6'h29]});
    wr(6'h28, 8'h98);
    repeat (2) pulse(11'h7ff);
    check({3'h0, coil_current_out}, {3'h0, mdl[6'h29]});
    pulse(11'h7ff);
    check({3'h0, coil_current_out}, {3'h0, mdl[6'h2a]});
    mdl[6'h2e] = mdl[6'h2a];
    rdc(6'h2e);
    wr(6'h2a, mdl[6'h29] + 8'h01);
    wr(6'h28, 8'h08);
    @(negedge clk_in);
    check({3'h0, coil_current_out}, {3'h0, mdl[6'h2a]});
    wr(6'h29, 8'h00);
    wr(6'h2a, 8'hff);
    wr(6'h26, 8'h00);
    wr(6'h27, 8'h0f);
    wr(6'h2b, 8'h05);
    wr(6'h28, 8'h88);
    repeat (2) pulse(11'h084);
    pulse(11'h090);
    check({3'h0, coil_current_out}, 11'h00b);
    pulse(11'h094);
    check({3'h0, coil_current_out}, 11'h00b);
    wrap_up();
  end
endmodule
